/* shared/bcc_map.svh */
/*
  Constants for the breaker control and counter block: timing counts,
  counter limits and reset values.
  Assumes a 25 MHz system clock; times are converted to cycles here.
*/
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define BCC_CLK_HZ 25000000
`define BCC_DISC_TIME_S 5
`define BCC_DISC_CYCLES (`BCC_DISC_TIME_S * `BCC_CLK_HZ)
`define BCC_RUN_TICK_CYCLES `BCC_CLK_HZ

// ****************************************************************
// Widths, limits and resets
// ****************************************************************
`define BCC_TIME_W 32
`define BCC_CNT_W 16
`define BCC_SUM_W 32
`define BCC_RUN_W 32
`define BCC_OPS_MAX 16'h2710
`define BCC_ZERO16 16'h0000
`define BCC_ZERO32 32'h0000_0000

`endif

/* shared/bcc_pkg.sv */
/*
  Types for the breaker control and counter block.
  Assumes bcc_map.svh supplies the widths.
*/
`include "bcc_map.svh"
package bcc_pkg;

  typedef enum logic [1:0]
  {
    BCC_ST_OPEN,
    BCC_ST_CLOSED,
    BCC_ST_FAIL,
    BCC_ST_UNKNOWN
  } bcc_state_t;

  typedef struct packed
  {
    logic trip;
    logic close;
  } bcc_req_t;

  typedef struct packed
  {
    logic [`BCC_CNT_W-1:0] ops;
    logic [`BCC_SUM_W-1:0] ia;
    logic [`BCC_SUM_W-1:0] ib;
    logic [`BCC_SUM_W-1:0] ic;
  } bcc_cnt_t;

  typedef struct packed
  {
    logic [`BCC_SUM_W-1:0] ia;
    logic [`BCC_SUM_W-1:0] ib;
    logic [`BCC_SUM_W-1:0] ic;
  } bcc_cur_t;

endpackage : bcc_pkg

/* logic/bcc_breaker_ctrl.sv */
/*
  Breaker control and condition counters: request checking, close delay,
  timed trip and close pulses, fail and discrepancy alarms, counters.
  Assumes contact and opto inputs are asynchronous pins; menu, remote,
  protection and settings inputs come from logic on i_clock.
*/
`include "bcc_map.svh"
module bcc_breaker_ctrl #(
  parameter logic [`BCC_TIME_W-1:0] DISC_CYCLES = `BCC_DISC_CYCLES,
  parameter logic [`BCC_TIME_W-1:0] RUN_TICK_CYCLES = `BCC_RUN_TICK_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_aux_contact_no,
  input wire logic i_aux_contact_nc,
  input wire logic i_no_in_use,
  input wire logic i_nc_in_use,
  input wire bcc_pkg::bcc_req_t i_menu_req,
  input wire bcc_pkg::bcc_req_t i_opto_req,
  input wire bcc_pkg::bcc_req_t i_remote_req,
  input wire logic i_protection_trip,
  input wire logic i_external_trip,
  input wire logic i_test_mode,
  input wire logic i_counter_clear,
  input wire bcc_pkg::bcc_cur_t i_broken_current,
  input wire logic [`BCC_TIME_W-1:0] i_close_delay,
  input wire logic [`BCC_TIME_W-1:0] i_trip_pulse,
  input wire logic [`BCC_TIME_W-1:0] i_close_pulse,
  output logic o_trip_coil,
  output logic o_close_coil,
  output logic o_close_pending,
  output logic o_breaker_open_fail_alarm,
  output logic o_breaker_shut_fail_alarm,
  output logic o_breaker_discrepancy_alarm,
  output bcc_pkg::bcc_state_t o_breaker_state,
  output bcc_pkg::bcc_cnt_t o_counters,
  output logic [`BCC_RUN_W-1:0] o_run_time
);

  typedef enum logic [1:0]
  {
    BCC_IDLE,
    BCC_DELAY,
    BCC_TRIP,
    BCC_CLOSE
  } bcc_fsm_t;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [1:0] pin_meta_q;
  logic [1:0] pin_meta_d;
  logic [1:0] pin_sync_q;
  logic [1:0] pin_sync_d;
  bcc_pkg::bcc_req_t opto_meta_q;
  bcc_pkg::bcc_req_t opto_meta_d;
  bcc_pkg::bcc_req_t opto_sync_q;
  bcc_pkg::bcc_req_t opto_sync_d;
  bcc_pkg::bcc_req_t opto_prev_q;
  bcc_pkg::bcc_req_t opto_prev_d;
  logic ext_meta_q;
  logic ext_meta_d;
  logic ext_sync_q;
  logic ext_sync_d;
  logic ext_prev_q;
  logic ext_prev_d;

  always_comb
  begin
    pin_meta_d = {i_aux_contact_no, i_aux_contact_nc};
    pin_sync_d = pin_meta_q;
    opto_meta_d = i_opto_req;
    opto_sync_d = opto_meta_q;
    opto_prev_d = opto_sync_q;
    ext_meta_d = i_external_trip;
    ext_sync_d = ext_meta_q;
    ext_prev_d = ext_sync_q;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
      opto_meta_q <= '0;
      opto_sync_q <= '0;
      opto_prev_q <= '0;
      ext_meta_q <= 1'h0;
      ext_sync_q <= 1'h0;
      ext_prev_q <= 1'h0;
    end
    else
    begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
      opto_meta_q <= opto_meta_d;
      opto_sync_q <= opto_sync_d;
      opto_prev_q <= opto_prev_d;
      ext_meta_q <= ext_meta_d;
      ext_sync_q <= ext_sync_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  // ****************************************************************
  // Contact decode
  // ****************************************************************
  logic no_c;
  logic nc_c;
  logic is_closed;
  logic is_open;
  bcc_pkg::bcc_state_t state_c;

  always_comb
  begin
    no_c = i_no_in_use ? pin_sync_q[1] : ~pin_sync_q[0];
    nc_c = i_nc_in_use ? pin_sync_q[0] : ~no_c;
    unique case ({no_c, nc_c})
      2'b01: state_c = bcc_pkg::BCC_ST_OPEN;
      2'b10: state_c = bcc_pkg::BCC_ST_CLOSED;
      2'b11: state_c = bcc_pkg::BCC_ST_FAIL;
      2'b00: state_c = bcc_pkg::BCC_ST_UNKNOWN;
    endcase
    is_closed = no_c;
    is_open = ~no_c;
  end

  // ****************************************************************
  // Requests and control sequence
  // ****************************************************************
  logic man_trip;
  logic man_close;
  logic opto_trip;
  logic opto_close;
  bcc_fsm_t fsm_q;
  bcc_fsm_t fsm_d;
  logic [`BCC_TIME_W-1:0] tmr_q;
  logic [`BCC_TIME_W-1:0] tmr_d;
  logic start_no_q;
  logic start_no_d;
  logic open_fail_q;
  logic open_fail_d;
  logic shut_fail_q;
  logic shut_fail_d;
  logic trip_event;

  always_comb
  begin
    opto_trip = opto_sync_q.trip & ~opto_prev_q.trip;
    opto_close = opto_sync_q.close & ~opto_prev_q.close;
    man_trip = i_menu_req.trip | opto_trip | i_remote_req.trip;
    man_close = i_menu_req.close | opto_close | i_remote_req.close;
    fsm_d = fsm_q;
    tmr_d = tmr_q;
    start_no_d = start_no_q;
    open_fail_d = open_fail_q;
    shut_fail_d = shut_fail_q;
    trip_event = 1'h0;
    if (i_protection_trip && fsm_q != BCC_TRIP)
    begin
      fsm_d = BCC_TRIP;
      tmr_d = i_trip_pulse;
      start_no_d = no_c;
      trip_event = 1'h1;
    end
    else
    begin
      unique case (fsm_q)
        BCC_IDLE:
        begin
          if (man_trip && is_closed)
          begin
            fsm_d = BCC_TRIP;
            tmr_d = i_trip_pulse;
            start_no_d = no_c;
            trip_event = 1'h1;
          end
          else if (man_close && is_open)
          begin
            fsm_d = BCC_DELAY;
            tmr_d = i_close_delay;
          end
        end
        BCC_DELAY:
        begin
          if (tmr_q == `BCC_ZERO32)
          begin
            fsm_d = BCC_CLOSE;
            tmr_d = i_close_pulse;
            start_no_d = no_c;
          end
          else
            tmr_d = tmr_q - 32'h1;
        end
        BCC_TRIP, BCC_CLOSE:
        begin
          if (tmr_q <= 32'h1)
          begin
            fsm_d = BCC_IDLE;
            if (no_c == start_no_q)
            begin
              if (fsm_q == BCC_TRIP)
                open_fail_d = 1'h1;
              else
                shut_fail_d = 1'h1;
            end
          end
          else
            tmr_d = tmr_q - 32'h1;
        end
      endcase
    end
    if (no_c != start_no_q && fsm_q == BCC_IDLE)
    begin
      open_fail_d = open_fail_q & no_c;
      shut_fail_d = shut_fail_q & ~no_c;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      fsm_q <= BCC_IDLE;
      tmr_q <= `BCC_ZERO32;
      start_no_q <= 1'h0;
      open_fail_q <= 1'h0;
      shut_fail_q <= 1'h0;
    end
    else
    begin
      fsm_q <= fsm_d;
      tmr_q <= tmr_d;
      start_no_q <= start_no_d;
      open_fail_q <= open_fail_d;
      shut_fail_q <= shut_fail_d;
    end
  end

  // ****************************************************************
  // Discrepancy, counters and run time
  // ****************************************************************
  logic [`BCC_TIME_W-1:0] disc_q;
  logic [`BCC_TIME_W-1:0] disc_d;
  logic disc_alarm_q;
  logic disc_alarm_d;
  bcc_pkg::bcc_cnt_t cnt_q;
  bcc_pkg::bcc_cnt_t cnt_d;
  logic [`BCC_TIME_W-1:0] tick_q;
  logic [`BCC_TIME_W-1:0] tick_d;
  logic [`BCC_RUN_W-1:0] run_q;
  logic [`BCC_RUN_W-1:0] run_d;

  always_comb
  begin
    disc_d = `BCC_ZERO32;
    disc_alarm_d = 1'h0;
    if (i_no_in_use && i_nc_in_use && (no_c == nc_c))
    begin
      disc_d = (disc_q > DISC_CYCLES) ? disc_q : disc_q + 32'h1;
      disc_alarm_d = disc_q > DISC_CYCLES;
    end
    cnt_d = cnt_q;
    if (i_counter_clear)
      cnt_d = '0;
    else if ((trip_event || (ext_sync_q && !ext_prev_q)) && !i_test_mode)
    begin
      if (cnt_q.ops < `BCC_OPS_MAX)
        cnt_d.ops = cnt_q.ops + 16'h1;
      cnt_d.ia = cnt_q.ia + i_broken_current.ia;
      cnt_d.ib = cnt_q.ib + i_broken_current.ib;
      cnt_d.ic = cnt_q.ic + i_broken_current.ic;
    end
    tick_d = `BCC_ZERO32;
    run_d = run_q;
    if (is_closed)
    begin
      tick_d = tick_q + 32'h1;
      if (tick_q >= RUN_TICK_CYCLES - 32'h1)
      begin
        tick_d = `BCC_ZERO32;
        run_d = run_q + 32'h1;
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      disc_q <= `BCC_ZERO32;
      disc_alarm_q <= 1'h0;
      cnt_q <= '0;
      tick_q <= `BCC_ZERO32;
      run_q <= `BCC_ZERO32;
    end
    else
    begin
      disc_q <= disc_d;
      disc_alarm_q <= disc_alarm_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      run_q <= run_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_trip_coil = (fsm_q == BCC_TRIP);
  assign o_close_coil = (fsm_q == BCC_CLOSE);
  assign o_close_pending = (fsm_q == BCC_DELAY);
  assign o_breaker_open_fail_alarm = open_fail_q;
  assign o_breaker_shut_fail_alarm = shut_fail_q;
  assign o_breaker_discrepancy_alarm = disc_alarm_q;
  assign o_breaker_state = state_c;
  assign o_counters = cnt_q;
  assign o_run_time = run_q;

endmodule : bcc_breaker_ctrl

/* tb/bcc_breaker_checker.sv */
/*
  Checker for bcc_breaker_ctrl, bound to its ports.
  Assumes steady settings and the single i_clock domain.
*/
`include "bcc_map.svh"
module bcc_breaker_checker (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_protection_trip,
  input wire logic i_test_mode,
  input wire logic i_counter_clear,
  input wire logic [`BCC_TIME_W-1:0] i_close_delay,
  input wire logic [`BCC_TIME_W-1:0] i_trip_pulse,
  input wire logic [`BCC_TIME_W-1:0] i_close_pulse,
  input wire logic o_trip_coil,
  input wire logic o_close_coil,
  input wire logic o_close_pending,
  input wire logic o_breaker_open_fail_alarm,
  input wire bcc_pkg::bcc_state_t o_breaker_state,
  input wire bcc_pkg::bcc_cnt_t o_counters
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  logic [31:0] tc_q, tc_d, cc_q, cc_d, pc_q, pc_d;
  always_comb
  begin
    tc_d = o_trip_coil ? tc_q + 32'h1 : 32'h0;
    cc_d = o_close_coil ? cc_q + 32'h1 : 32'h0;
    pc_d = o_close_pending ? pc_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_clock)
  begin
    tc_q <= i_reset ? 32'h0 : tc_d;
    cc_q <= i_reset ? 32'h0 : cc_d;
    pc_q <= i_reset ? 32'h0 : pc_d;
  end
  sequence s_close_busy;
    (o_close_pending || o_close_coil) && !o_trip_coil;
  endsequence
  sequence s_close_begin;
    $rose(o_close_pending);
  endsequence
  a_trip_len: assert property ($fell(o_trip_coil) |-> tc_q == i_trip_pulse)
    else $error("trip pulse length wrong");
  a_shut_len: assert property (
    $fell(o_close_coil) && !o_trip_coil |-> cc_q == i_close_pulse)
    else $error("close pulse length wrong");
  a_close_wait: assert property ($rose(o_close_coil) |-> pc_q == i_close_delay + 32'h1)
    else $error("close delay wrong");
  a_trip_perm: assert property (
    $rose(o_trip_coil) && !$past(i_protection_trip)
    |-> $past(o_breaker_state) == bcc_pkg::BCC_ST_CLOSED)
    else $error("trip while not closed");
  a_shut_perm: assert property (
    s_close_begin |-> $past(o_breaker_state) == bcc_pkg::BCC_ST_OPEN)
    else $error("close while not open");
  a_prot_wins: assert property (
    s_close_busy ##0 i_protection_trip |=> o_trip_coil && !o_close_coil && !o_close_pending)
    else $error("protection trip did not override close");
  a_test_hold: assert property (i_test_mode && !i_counter_clear |=> $stable(o_counters))
    else $error("counters moved in test mode");
  a_clear_zero: assert property (i_counter_clear |=> o_counters == '0)
    else $error("counters not cleared");
  a_open_alarm: assert property (
    $fell(o_trip_coil) && o_breaker_state == bcc_pkg::BCC_ST_CLOSED
    |-> o_breaker_open_fail_alarm)
    else $error("open fail alarm missing");
endmodule : bcc_breaker_checker

bind bcc_breaker_ctrl bcc_breaker_checker chk (.i_clock, .i_reset, .i_protection_trip,
  .i_test_mode, .i_counter_clear, .i_close_delay, .i_trip_pulse, .i_close_pulse, .o_trip_coil,
  .o_close_coil, .o_close_pending, .o_breaker_open_fail_alarm, .o_breaker_state, .o_counters);

/* tb/bcc_breaker_model.sv */
/*
  Breaker model: aux contacts follow the coils after a short travel.
  Assumes coils come from logic on the same clock.
*/
module bcc_breaker_model (
  input wire logic i_clock,
  input wire logic i_trip_coil,
  input wire logic i_close_coil,
  input wire logic i_stuck,
  input wire logic i_split,
  output logic o_no,
  output logic o_nc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic shut_q = 1'b0;
  logic [1:0] trv_q = 2'h0;
  // Stuck mode models a breaker that ignores its coils
  always_ff @(posedge i_clock)
  begin
    trv_q <= (i_trip_coil | i_close_coil) & !i_stuck ? trv_q + 2'h1 : 2'h0;
    if (trv_q == 2'h2)
      shut_q <= i_close_coil;
  end
  assign o_no = shut_q;
  assign o_nc = i_split ? shut_q : !shut_q;
endmodule : bcc_breaker_model

/* tb/bcc_breaker_ctrl_tb.sv */
/*
  Bench for bcc_breaker_ctrl: scenario tasks, breaker model, checker.
  Assumes the design files and bcc_pkg are compiled first.
*/
`include "bcc_map.svh"
module bcc_breaker_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] CUR = 32'h5;
  localparam logic [31:0] PULSE = 32'h8;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic stuck = 1'b0;
  logic split = 1'b0;
  logic no_use = 1'b1;
  logic nc_use = 1'b1;
  logic prot = 1'b0;
  logic ext = 1'b0;
  logic test = 1'b0;
  logic clr = 1'b0;
  logic [31:0] dly = 32'h4;
  bcc_pkg::bcc_req_t menu = 2'h0;
  bcc_pkg::bcc_req_t opto = 2'h0;
  bcc_pkg::bcc_req_t remote = 2'h0;
  logic no_w, nc_w, trip_c, close_c, pend, ofail, sfail, disc;
  bcc_pkg::bcc_state_t st;
  bcc_pkg::bcc_cnt_t cnt;
  logic [31:0] run;
  int checks = 0;
  int fails = 0;
  int cyc_n = 0;
  bcc_breaker_ctrl #(.DISC_CYCLES(32'h14), .RUN_TICK_CYCLES(32'hA)) dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_aux_contact_no(no_w), .i_aux_contact_nc(nc_w),
    .i_no_in_use(no_use), .i_nc_in_use(nc_use), .i_menu_req(menu), .i_opto_req(opto),
    .i_remote_req(remote), .i_protection_trip(prot), .i_external_trip(ext),
    .i_test_mode(test), .i_counter_clear(clr), .i_broken_current({3{CUR}}),
    .i_close_delay(dly), .i_trip_pulse(PULSE), .i_close_pulse(PULSE), .o_trip_coil(trip_c),
    .o_close_coil(close_c), .o_close_pending(pend), .o_breaker_open_fail_alarm(ofail),
    .o_breaker_shut_fail_alarm(sfail), .o_breaker_discrepancy_alarm(disc),
    .o_breaker_state(st), .o_counters(cnt), .o_run_time(run));
  bcc_breaker_model bm (.i_clock(i_clock), .i_trip_coil(trip_c), .i_close_coil(close_c),
    .i_stuck(stuck), .i_split(split), .o_no(no_w), .o_nc(nc_w));
  initial
    forever #20 i_clock = ~i_clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : cyc
  task automatic req(input int s, input logic [1:0] r);
    case (s)
      0: menu = r;
      1: opto = r;
      default: remote = r;
    endcase
    cyc(1);
    menu = 2'h0;
    opto = 2'h0;
    remote = 2'h0;
  endtask : req
  task automatic t_cycle(input int s);
    logic [15:0] ops;
    logic [31:0] r;
    req(s, 2'h1);
    cyc(2);
    req(s, 2'h1);
    cyc(25);
    chk(st, bcc_pkg::BCC_ST_CLOSED);
    r = run;
    cyc(20);
    chk(run, r + 32'h2);
    split = 1'b1;
    cyc(3);
    chk(st, bcc_pkg::BCC_ST_FAIL);
    split = 1'b0;
    cyc(3);
    req(s, 2'h1);
    cyc(3);
    chk(pend, 1'b0);
    ops = cnt.ops;
    req(s, 2'h2);
    cyc(25);
    chk(st, bcc_pkg::BCC_ST_OPEN);
    chk(cnt.ops, ops + 16'h1);
  endtask : t_cycle
  task automatic t_prot();
    logic [15:0] ops;
    ops = cnt.ops;
    req(0, 2'h2);
    cyc(2);
    chk(trip_c, 1'b0);
    dly = 32'hA;
    req(2, 2'h1);
    cyc(4);
    chk(pend, 1'b1);
    prot = 1'b1;
    cyc(1);
    prot = 1'b0;
    chk(trip_c, 1'b1);
    chk(pend | close_c, 1'b0);
    cyc(25);
    chk(cnt.ops, ops + 16'h1);
    chk(ofail, 1'b1);
    dly = 32'h4;
  endtask : t_prot
  task automatic t_fail(input logic [1:0] r);
    chk(r[1] ? ofail : sfail, 1'b0);
    stuck = 1'b1;
    req(0, r);
    cyc(30);
    chk(r[1] ? ofail : sfail, 1'b1);
    stuck = 1'b0;
    req(0, r);
    cyc(30);
    chk(r[1] ? ofail : sfail, 1'b0);
  endtask : t_fail
  task automatic t_count();
    logic [15:0] ops;
    ops = cnt.ops;
    chk(cnt.ia, {16'h0, ops} * CUR);
    test = 1'b1;
    ext = 1'b1;
    cyc(6);
    chk(cnt.ops, ops);
    test = 1'b0;
    ext = 1'b0;
    cyc(2);
    ext = 1'b1;
    cyc(6);
    chk(cnt.ops, ops + 16'h1);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    chk(|cnt, 1'b0);
  endtask : t_count
  task automatic t_disc();
    split = 1'b1;
    nc_use = 1'b0;
    cyc(30);
    chk(st, bcc_pkg::BCC_ST_OPEN);
    chk(disc, 1'b0);
    nc_use = 1'b1;
    no_use = 1'b0;
    cyc(2);
    chk(st, bcc_pkg::BCC_ST_CLOSED);
    chk(disc, 1'b0);
    no_use = 1'b1;
    cyc(12);
    chk(st, bcc_pkg::BCC_ST_UNKNOWN);
    chk(disc, 1'b0);
    cyc(15);
    chk(disc, 1'b1);
    split = 1'b0;
    cyc(4);
    chk(disc, 1'b0);
  endtask : t_disc
  task final_report();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  always @(posedge i_clock)
  begin
    cyc_n++;
    if (cyc_n == 3000)
    begin
      fails++;
      final_report();
    end
  end
  initial
  begin
    cyc(5);
    i_reset = 1'b0;
    cyc(3);
    chk(st, bcc_pkg::BCC_ST_OPEN);
    for (int s = 0; s < 3; s++)
      t_cycle(s);
    t_fail(2'h1);
    t_fail(2'h2);
    t_prot();
    t_count();
    t_disc();
    final_report();
  end
endmodule : bcc_breaker_ctrl_tb
